/* File: etcsw_tx_client.sv */
// Transmit client stream port: takes four-word groups, sends them one word per cycle.
// Assumes the client holds its inputs until din_req and keeps packets gap free.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Data bus is 256 bits, big-endian, top word in bits 255 to 192.
// - Four start markers; a packet starts only in a word's top byte.
// - Marker bit 0 refers to the lowest word, bits 63 to 0.
// - Four end markers flag the word holding a packet's last byte.
// - Three-bit empty count per word gives invalid bytes of an ending word.
// - Empty counts of words not ending a packet are ignored.
// - Four-bit idle marker, one bit per word, flags words carrying no frame data.
// - din_req shows the presented word group is taken this cycle.
// - Error bit z is sampled only when end marker bit z is set, corrupting that packet.
// - A packet with injected error returns malformed in loopback.
// - Device drives the transmit MAC clock that times every interface signal.
module etcsw_tx_client
    import etcsw_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    output logic                          clk_txmac,
    input  wire logic [ETCSW_BUS_W-1:0]   din,
    input  wire logic [ETCSW_WORDS-1:0]   din_sop,
    input  wire logic [ETCSW_WORDS-1:0]   din_eop,
    input  wire logic [3*ETCSW_WORDS-1:0] din_eop_empty,
    input  wire logic [ETCSW_WORDS-1:0]   din_idle,
    input  wire logic [ETCSW_WORDS-1:0]   tx_error,
    output logic                          din_req,
    output logic      [ETCSW_WORD_W-1:0]  link_data_q,
    output logic                          link_valid_q,
    output logic                          link_sop_q,
    output logic                          link_eop_q,
    output logic      [ETCSW_CNT_W-1:0]   link_bytes_q,
    output logic                          link_err_q,
    output logic                          frame_short_q,
    output logic                          frame_gap_q
);

    logic [ETCSW_WORD_W-1:0] lane_word [ETCSW_WORDS];
    logic [ETCSW_CNT_W-1:0]  lane_bytes[ETCSW_WORDS];
    logic [ETCSW_WORDS-1:0]  lane_err;

    logic [ETCSW_WORD_W-1:0] word_q [ETCSW_WORDS];
    logic [ETCSW_WORD_W-1:0] word_d [ETCSW_WORDS];
    logic [ETCSW_CNT_W-1:0]  bytes_q[ETCSW_WORDS];
    logic [ETCSW_CNT_W-1:0]  bytes_d[ETCSW_WORDS];
    logic [ETCSW_WORDS-1:0]  sop_q, sop_d;
    logic [ETCSW_WORDS-1:0]  eop_q, eop_d;
    logic [ETCSW_WORDS-1:0]  err_q, err_d;
    logic [ETCSW_WORDS-1:0]  pend_q, pend_d;
    logic [ETCSW_WORDS-1:0]  sel_oh;
    logic [1:0]              sel_idx;
    logic                    accept;

    logic [ETCSW_WORD_W-1:0] link_data_d;
    logic                    link_valid_d, link_sop_d, link_eop_d, link_err_d;
    logic [ETCSW_CNT_W-1:0]  link_bytes_d;

    logic                    open_q, open_d;
    logic [ETCSW_CNT_W-1:0]  len_q, len_d;
    logic                    frame_short_d, frame_gap_d;

    // The interface clock is the block clock, driven out to the client
    assign clk_txmac = sys_clk;

    // Marker bit z, empty bits [3z+2:3z] and error bit z all refer to din word z
    genvar gz;
    generate
        for (gz = 0; gz < ETCSW_WORDS; gz++)
        begin : g_lane
            etcsw_lane u_lane (
                .word_i  (din[gz*ETCSW_WORD_W +: ETCSW_WORD_W]),
                .eop_i   (din_eop[gz]),
                .empty_i (din_eop_empty[gz*ETCSW_EMPTY_W +: ETCSW_EMPTY_W]),
                .err_i   (tx_error[gz]),
                .word_o  (lane_word[gz]),
                .bytes_o (lane_bytes[gz]),
                .err_o   (lane_err[gz])
            );
        end
    endgenerate

    // Highest pending word goes out first, so bytes leave in big-endian order
    always_comb
    begin
        sel_oh  = ETCSW_NONE;
        sel_idx = 2'h0;
        for (int i = 0; i < ETCSW_WORDS; i++)
        begin
            if (pend_q[i])
            begin
                sel_oh  = 4'h1 << i;
                sel_idx = 2'(i);
            end
        end
    end

    // Zero ready latency: the group is taken in the cycle din_req is high
    assign din_req = reset_n && ((pend_q & ~sel_oh) == ETCSW_NONE);
    assign accept  = din_req;

    always_comb
    begin
        pend_d = pend_q & ~sel_oh;
        sop_d  = sop_q;
        eop_d  = eop_q;
        err_d  = err_q;
        for (int i = 0; i < ETCSW_WORDS; i++)
        begin
            word_d[i]  = word_q[i];
            bytes_d[i] = bytes_q[i];
        end
        if (accept)
        begin
            pend_d = ~din_idle;
            sop_d  = din_sop;
            eop_d  = din_eop;
            err_d  = lane_err;
            for (int i = 0; i < ETCSW_WORDS; i++)
            begin
                word_d[i]  = lane_word[i];
                bytes_d[i] = lane_bytes[i];
            end
        end
    end

    always_comb
    begin
        link_valid_d = |pend_q;
        link_data_d  = word_q[sel_idx];
        link_sop_d   = |(sop_q & sel_oh);
        link_eop_d   = |(eop_q & sel_oh);
        link_err_d   = |(err_q & sel_oh);
        link_bytes_d = link_valid_d ? bytes_q[sel_idx] : ETCSW_NONE;
    end

    // Packet framing check on the accepted group, walked from the top word down
    always_comb
    begin
        logic [4:0] sum;
        sum           = 5'h00;
        open_d        = open_q;
        len_d         = len_q;
        frame_short_d = 1'b0;
        frame_gap_d   = 1'b0;
        if (accept)
        begin
            for (int i = ETCSW_WORDS - 1; i >= 0; i--)
            begin
                if (din_idle[i])
                begin
                    frame_gap_d = frame_gap_d | open_d;
                end
                else
                begin
                    if (din_sop[i])
                    begin
                        open_d = 1'b1;
                        len_d  = ETCSW_NONE;
                    end
                    sum   = {1'b0, len_d} + {1'b0, lane_bytes[i]};
                    len_d = sum[4] ? ETCSW_LEN_SAT : sum[3:0];
                    if (din_eop[i])
                    begin
                        frame_short_d = frame_short_d | (len_d < ETCSW_MIN_FRAME);
                        open_d        = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pend_q        <= ETCSW_NONE;
            sop_q         <= ETCSW_NONE;
            eop_q         <= ETCSW_NONE;
            err_q         <= ETCSW_NONE;
            for (int i = 0; i < ETCSW_WORDS; i++)
            begin
                word_q[i]  <= ETCSW_WORD_RST;
                bytes_q[i] <= ETCSW_NONE;
            end
            link_data_q   <= ETCSW_WORD_RST;
            link_valid_q  <= 1'b0;
            link_sop_q    <= 1'b0;
            link_eop_q    <= 1'b0;
            link_err_q    <= 1'b0;
            link_bytes_q  <= ETCSW_NONE;
            open_q        <= 1'b0;
            len_q         <= ETCSW_NONE;
            frame_short_q <= 1'b0;
            frame_gap_q   <= 1'b0;
        end
        else
        begin
            pend_q        <= pend_d;
            sop_q         <= sop_d;
            eop_q         <= eop_d;
            err_q         <= err_d;
            for (int i = 0; i < ETCSW_WORDS; i++)
            begin
                word_q[i]  <= word_d[i];
                bytes_q[i] <= bytes_d[i];
            end
            link_data_q   <= link_data_d;
            link_valid_q  <= link_valid_d;
            link_sop_q    <= link_sop_d;
            link_eop_q    <= link_eop_d;
            link_err_q    <= link_err_d;
            link_bytes_q  <= link_bytes_d;
            open_q        <= open_d;
            len_q         <= len_d;
            frame_short_q <= frame_short_d;
            frame_gap_q   <= frame_gap_d;
        end
    end

    property p_full_group_drains;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 |-> ##2 link_valid_q [*4];
    endproperty
    a_full_group_drains: assert property (p_full_group_drains) else $error("full group not sent in four words");

    property p_top_word_first;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 && !din_eop[3] |-> ##2 link_data_q == $past(din[255:192], 2);
    endproperty
    a_top_word_first: assert property (p_top_word_first) else $error("top word not sent first");

    property p_low_word_last;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 && din_eop == 4'h0 |-> ##5 link_data_q == $past(din[63:0], 5);
    endproperty
    a_low_word_last: assert property (p_low_word_last) else $error("word 0 not sent last");

    property p_all_idle_skipped;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'hF |-> ##2 !link_valid_q;
    endproperty
    a_all_idle_skipped: assert property (p_all_idle_skipped) else $error("idle word was sent");

    property p_sop_marked;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 && din_sop == 4'h8 |-> ##2 link_sop_q ##1 !link_sop_q;
    endproperty
    a_sop_marked: assert property (p_sop_marked) else $error("start marker misplaced");

    property p_empty_count;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 && din_eop[3]
            |-> ##2 link_eop_q && link_bytes_q == 4'h8 - {1'b0, $past(din_eop_empty[11:9], 2)};
    endproperty
    a_empty_count: assert property (p_empty_count) else $error("end word byte count wrong");

    property p_empty_ignored;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 && din_eop == 4'h0 |-> ##2 link_bytes_q == 4'h8 && !link_eop_q;
    endproperty
    a_empty_ignored: assert property (p_empty_ignored) else $error("empty count used without end");

    property p_error_injected;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 && din_eop[3] && tx_error[3]
            |-> ##2 link_err_q && link_data_q == ~$past(din[255:192], 2);
    endproperty
    a_error_injected: assert property (p_error_injected) else $error("error not injected");

    property p_error_ignored;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_eop == 4'h0 |-> ##2 !link_err_q;
    endproperty
    a_error_ignored: assert property (p_error_ignored) else $error("error bit taken outside end cycle");

    property p_req_held;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && din_idle == 4'h0 |-> ##1 !din_req [*3] ##1 din_req;
    endproperty
    a_req_held: assert property (p_req_held) else $error("new group taken while words remain");

    property p_short_flagged;
        @(posedge sys_clk) disable iff (!reset_n)
        din_req && (din_sop & din_eop & ~din_idle) != 4'h0 |-> ##1 frame_short_q;
    endproperty
    a_short_flagged: assert property (p_short_flagged) else $error("one-word packet not flagged short");

    property p_idle_link_quiet;
        @(posedge sys_clk) disable iff (!reset_n)
        !link_valid_q |-> link_bytes_q == 4'h0 && !link_sop_q && !link_eop_q && !link_err_q;
    endproperty
    a_idle_link_quiet: assert property (p_idle_link_quiet) else $error("markers shown without a word");

    c_back_to_back: cover property (@(posedge sys_clk) disable iff (!reset_n) din_req ##1 din_req);
    c_error_end: cover property (@(posedge sys_clk) disable iff (!reset_n) link_err_q && link_eop_q);
    c_short: cover property (@(posedge sys_clk) disable iff (!reset_n) frame_short_q);
    c_gap: cover property (@(posedge sys_clk) disable iff (!reset_n) frame_gap_q);
    c_full_group: cover property (@(posedge sys_clk) disable iff (!reset_n) din_req && din_idle == 4'h0);

endmodule : etcsw_tx_client

`default_nettype wire

/* File: etcsw_pkg.sv */
// Constants shared by the transmit client stream block and its lane decoder.
// Assumes a single clock domain; the design's main widths and limits are named here.
`default_nettype none

package etcsw_pkg;

    localparam int          ETCSW_WORDS          = 4;
    localparam int          ETCSW_WORD_W         = 64;
    localparam int          ETCSW_BUS_W          = ETCSW_WORDS * ETCSW_WORD_W;
    localparam int          ETCSW_EMPTY_W        = 3;
    localparam int          ETCSW_CNT_W          = 4;
    localparam logic [3:0]  ETCSW_BYTES_PER_WORD = 4'h8;
    localparam logic [3:0]  ETCSW_MIN_FRAME      = 4'h9;
    localparam logic [3:0]  ETCSW_LEN_SAT        = 4'hF;
    localparam logic [3:0]  ETCSW_NONE           = 4'h0;
    localparam logic [3:0]  ETCSW_ALL_IDLE       = 4'hF;
    localparam logic [63:0] ETCSW_WORD_RST       = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ETCSW_CORRUPT_MASK   = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam real         ETCSW_TXMAC_MHZ      = 390.625;
    localparam real         ETCSW_SYS_CLK_MHZ    = 100.0;

endpackage : etcsw_pkg

`default_nettype wire

/* File: etcsw_lane.sv */
// One 64-bit lane of the client bus: byte count and error corruption.
// Assumes the caller provides the lane's own end marker, empty count and error bit.
`timescale 1ns/10ps
`default_nettype none

module etcsw_lane
    import etcsw_pkg::*;
(
    input  wire logic [ETCSW_WORD_W-1:0]  word_i,
    input  wire logic                     eop_i,
    input  wire logic [ETCSW_EMPTY_W-1:0] empty_i,
    input  wire logic                     err_i,
    output logic      [ETCSW_WORD_W-1:0]  word_o,
    output logic      [ETCSW_CNT_W-1:0]   bytes_o,
    output logic                          err_o
);

    always_comb
    begin
        // Empty count only matters on an ending word
        if (eop_i)
        begin
            bytes_o = ETCSW_BYTES_PER_WORD - {1'b0, empty_i};
        end
        else
        begin
            bytes_o = ETCSW_BYTES_PER_WORD;
        end
        // Error bit only counts in an end cycle; inverting the final word breaks the check sequence
        err_o  = eop_i & err_i;
        word_o = err_o ? (word_i ^ ETCSW_CORRUPT_MASK) : word_i;
    end

endmodule : etcsw_lane

`default_nettype wire

/* File: etcsw_client_model.sv */
// Client frame source that feeds the transmit client stream port.
// Assumes the bench calls send_group and that sys_clk also clocks the port.
`timescale 1ns/10ps
`default_nettype none

module etcsw_client_model
    import etcsw_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     din_req,
    output logic      [ETCSW_BUS_W-1:0]   din,
    output logic      [ETCSW_WORDS-1:0]   din_sop,
    output logic      [ETCSW_WORDS-1:0]   din_eop,
    output logic      [3*ETCSW_WORDS-1:0] din_eop_empty,
    output logic      [ETCSW_WORDS-1:0]   din_idle,
    output logic      [ETCSW_WORDS-1:0]   tx_error
);
    initial
    begin
        din           = '0;
        din_sop       = ETCSW_NONE;
        din_eop       = ETCSW_NONE;
        din_eop_empty = 12'h000;
        din_idle      = ETCSW_ALL_IDLE;
        tx_error      = ETCSW_NONE;
    end

    // One whole group per call; callers other than test_flags keep packets gap free and nine bytes or longer
    task automatic send_group(
        input logic [255:0] d,
        input logic [3:0]   sop,
        input logic [3:0]   eop,
        input logic [11:0]  empty,
        input logic [3:0]   idle,
        input logic [3:0]   err
    );
        int n;
        n = 0;
        @(negedge sys_clk);
        din           = d;
        din_sop       = sop;
        din_eop       = eop;
        din_eop_empty = empty;
        din_idle      = idle;
        tx_error      = err;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (din_req !== 1'h1 && n < 50);
        @(negedge sys_clk);
        // Released data and empty lines show the inverse and markers go idle, so stale data cannot pass
        din           = ~d;
        din_eop_empty = ~empty;
        din_sop       = ETCSW_NONE;
        din_eop       = ETCSW_NONE;
        din_idle      = ETCSW_ALL_IDLE;
        tx_error      = ETCSW_NONE;
    endtask : send_group
endmodule : etcsw_client_model

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the transmit client stream port.
// Assumes the client model drives the port and the link outputs are free running.
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import etcsw_pkg::*;
;
    localparam logic [63:0] PA = 64'h0123_4567_89AB_CDEF;
    localparam logic [63:0] PB = 64'hFEDC_BA98_7654_3210;
    logic                     sys_clk;
    logic                     reset_n;
    logic                     clk_txmac;
    logic [ETCSW_BUS_W-1:0]   din;
    logic [ETCSW_WORDS-1:0]   din_sop;
    logic [ETCSW_WORDS-1:0]   din_eop;
    logic [3*ETCSW_WORDS-1:0] din_eop_empty;
    logic [ETCSW_WORDS-1:0]   din_idle;
    logic [ETCSW_WORDS-1:0]   tx_error;
    logic                     din_req;
    logic [ETCSW_WORD_W-1:0]  link_data_q;
    logic                     link_valid_q;
    logic                     link_sop_q;
    logic                     link_eop_q;
    logic [ETCSW_CNT_W-1:0]   link_bytes_q;
    logic                     link_err_q;
    logic                     frame_short_q;
    logic                     frame_gap_q;
    logic [70:0]              got_q[$];
    int                       bad_count;
    int                       checked;
    int                       short_n;
    int                       gap_n;

    etcsw_tx_client i_etcsw_tx_client (.sys_clk(sys_clk), .reset_n(reset_n), .clk_txmac(clk_txmac),
        .din(din), .din_sop(din_sop), .din_eop(din_eop), .din_eop_empty(din_eop_empty),
        .din_idle(din_idle), .tx_error(tx_error), .din_req(din_req), .link_data_q(link_data_q),
        .link_valid_q(link_valid_q), .link_sop_q(link_sop_q), .link_eop_q(link_eop_q),
        .link_bytes_q(link_bytes_q), .link_err_q(link_err_q), .frame_short_q(frame_short_q),
        .frame_gap_q(frame_gap_q));

    etcsw_client_model i_etcsw_client_model (.sys_clk(sys_clk), .din_req(din_req), .din(din),
        .din_sop(din_sop), .din_eop(din_eop), .din_eop_empty(din_eop_empty), .din_idle(din_idle),
        .tx_error(tx_error));

    initial sys_clk = 1'h0;
    always #5 sys_clk = ~sys_clk;

    // Collects link words and framing pulses
    always @(posedge sys_clk)
    begin
        if (reset_n === 1'h1 && link_valid_q === 1'h1)
            got_q.push_back({link_err_q, link_sop_q, link_eop_q, link_bytes_q, link_data_q});
        if (frame_short_q === 1'h1)
            short_n++;
        if (frame_gap_q === 1'h1)
            gap_n++;
    end

    task automatic check(input string name, input logic [70:0] exp, input logic [70:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic ew(input string n, input logic e, input logic s, input logic p,
                      input logic [3:0] b, input logic [63:0] d);
        int k;
        k = 0;
        while (got_q.size() == 0 && k < 20)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (got_q.size() == 0)
            check(n, {e, s, p, b, d}, 71'bx);
        else
            check(n, {e, s, p, b, d}, got_q.pop_front());
    endtask : ew

    // Back-to-back groups: order, markers, empty counts, error injection
    task automatic test_stream;
        i_etcsw_client_model.send_group({PA ^ 64'h3, PA ^ 64'h2, PA ^ 64'h1, PA},
                                        4'h8, 4'h1, 12'h003, 4'h0, 4'h0);
        i_etcsw_client_model.send_group({PB ^ 64'h3, PB ^ 64'h2, PB ^ 64'h1, PB},
                                        4'h8, 4'h2, 12'hE10, 4'h1, 4'hA);
        ew("a3", 1'h0, 1'h1, 1'h0, 4'h8, PA ^ 64'h3);
        ew("a2", 1'h0, 1'h0, 1'h0, 4'h8, PA ^ 64'h2);
        ew("a1", 1'h0, 1'h0, 1'h0, 4'h8, PA ^ 64'h1);
        ew("a0", 1'h0, 1'h0, 1'h1, 4'h5, PA);
        ew("b3", 1'h0, 1'h1, 1'h0, 4'h8, PB ^ 64'h3);
        ew("b2", 1'h0, 1'h0, 1'h0, 4'h8, PB ^ 64'h2);
        ew("b1", 1'h1, 1'h0, 1'h1, 4'h6, ~(PB ^ 64'h1));
        check("stream flags", 71'h0, 71'(short_n + gap_n));
        $display("test_stream done");
    endtask : test_stream

    // Packet spanning two groups, ending in word 3 with an error, then a new packet
    task automatic test_span;
        i_etcsw_client_model.send_group({PA, PB, PA ^ 64'h4, PB ^ 64'h4},
                                        4'h8, 4'h0, 12'hFFF, 4'h0, 4'hF);
        i_etcsw_client_model.send_group({PB, PA, PB ^ 64'h5, PA ^ 64'h5},
                                        4'h4, 4'h9, 12'h400, 4'h0, 4'h8);
        ew("c3", 1'h0, 1'h1, 1'h0, 4'h8, PA);
        ew("c2", 1'h0, 1'h0, 1'h0, 4'h8, PB);
        ew("c1", 1'h0, 1'h0, 1'h0, 4'h8, PA ^ 64'h4);
        ew("c0", 1'h0, 1'h0, 1'h0, 4'h8, PB ^ 64'h4);
        ew("d3", 1'h1, 1'h0, 1'h1, 4'h6, ~PB);
        ew("d2", 1'h0, 1'h1, 1'h0, 4'h8, PA);
        ew("d1", 1'h0, 1'h0, 1'h0, 4'h8, PB ^ 64'h5);
        ew("d0", 1'h0, 1'h0, 1'h1, 4'h8, PA ^ 64'h5);
        check("span flags", 71'h0, 71'(short_n + gap_n));
        $display("test_span done");
    endtask : test_span

    // Short frame and an idle word inside an open packet are flagged
    task automatic test_flags;
        i_etcsw_client_model.send_group({PA, PB, PA, PB}, 4'hC, 4'h9, 12'h000, 4'h0, 4'h0);
        ew("s3", 1'h0, 1'h1, 1'h1, 4'h8, PA);
        ew("s2", 1'h0, 1'h1, 1'h0, 4'h8, PB);
        ew("s1", 1'h0, 1'h0, 1'h0, 4'h8, PA);
        ew("s0", 1'h0, 1'h0, 1'h1, 4'h8, PB);
        check("short count", 71'h1, 71'(short_n));
        i_etcsw_client_model.send_group({PB, PA, PB, PA}, 4'h8, 4'h1, 12'h007, 4'h4, 4'h0);
        ew("g3", 1'h0, 1'h1, 1'h0, 4'h8, PB);
        ew("g1", 1'h0, 1'h0, 1'h0, 4'h8, PB);
        ew("g0", 1'h1 & 1'h0, 1'h0, 1'h1, 4'h1, PA);
        check("gap count", 71'h1, 71'(gap_n));
        repeat (8) @(posedge sys_clk);
        check("leftover", 71'h0, 71'(got_q.size()));
        $display("test_flags done");
    endtask : test_flags

    // Interface clock follows the block clock
    task automatic test_clock;
        @(negedge sys_clk);
        #1;
        check("clk low", 71'h0, {70'h0, clk_txmac});
        @(posedge sys_clk);
        #1;
        check("clk high", 71'h1, {70'h0, clk_txmac});
        $display("test_clock done");
    endtask : test_clock

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        #50000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        reset_n = 1'h0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'h1;
        test_stream();
        test_span();
        test_flags();
        test_clock();
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
